// ===== serial_memory_spi_command_front.sv
// SPI slave command front of a small serial memory.
// Assumes pins arrive asynchronous to clk; memory read data is valid
// the cycle after mem_rd is seen high; busy_in comes from clk logic.
//
// Contract
// - Modes 0 and 3 only, either idle level
// - Sample on rising, present on falling edge
// - MSB first, first byte is instruction
// - Read, fast read, status read framing
// - Write, page erase, chip erase framing
// - Decode no-argument opcodes
// - Status: busy bit0, latch bit1, rest zero
// - Busy shows program or erase running
// - Latch clear at reset; refuse writes
// - Successful write-type commands clear latch
// - Partial byte at deselect: no effect (wake-up still acts at the last bit of its opcode)
// - Write-disable clears latch unless busy
// - Status byte repeats while selected
// - Full 16-bit address, low 12 used
// - Ignore input, shift addressed byte out
// - Increment address per byte, wrap
// - Deselected: ignore input, output released
`timescale 1ns/1ps
`default_nettype none

module serial_memory_spi_command_front #(
  parameter int ADDR_W = spi_front_pkg::ADDR_BITS_USED
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic serial_in,
  input wire logic busy_in,
  input wire logic [7:0] mem_rdata,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic prog_start,
  output logic [7:0] prog_op,
  output logic [ADDR_W-1:0] prog_addr,
  output logic write_enable_latch,
  output logic power_down
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic cs_s1_r, cs_s2_r, cs_d_r;
  logic sck_s1_r, sck_s2_r, sck_d_r;
  logic sin_s1_r, sin_s2_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_d_r <= 1'b0;
      sin_s1_r <= 1'b0;
      sin_s2_r <= 1'b0;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
      sck_s1_r <= sck;
      sck_s2_r <= sck_s1_r;
      sck_d_r <= sck_s2_r;
      sin_s1_r <= serial_in;
      sin_s2_r <= sin_s1_r;
    end
  end

  logic cs_rise, cs_fall, sck_rise, sck_fall;
  // Only edges count, so either idle level of the clock works
  assign cs_rise = cs_s2_r & ~cs_d_r;
  assign cs_fall = ~cs_s2_r & cs_d_r;
  assign sck_rise = sck_s2_r & ~sck_d_r;
  assign sck_fall = ~sck_s2_r & sck_d_r;

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  spi_front_pkg::front_state_t state_r, state_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [2:0] byte_cnt_r, byte_cnt_nxt;
  logic [7:0] op_r, op_nxt;
  logic [spi_front_pkg::ADDR_BITS_SENT-1:0] rx_r, rx_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic out_r, out_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic mem_rd_r, mem_rd_nxt;
  logic load_r, load_nxt;
  logic wel_r, wel_nxt;
  logic pd_r, pd_nxt;
  logic prog_start_r, prog_start_nxt;
  logic [7:0] prog_op_r, prog_op_nxt;
  logic [ADDR_W-1:0] prog_addr_r, prog_addr_nxt;

  logic [7:0] status_byte;
  logic [7:0] rx_byte;
  logic [spi_front_pkg::ADDR_BITS_SENT-1:0] rx_word;
  logic last_bit;

  always_comb begin
    status_byte = spi_front_pkg::STATUS_RESERVED;
    status_byte[spi_front_pkg::STATUS_WEL_BIT] = wel_r;
    status_byte[spi_front_pkg::STATUS_BUSY_BIT] = busy_in;
  end

  // MSB first: new bit enters at the bottom
  assign rx_word = {rx_r[spi_front_pkg::ADDR_BITS_SENT-2:0], sin_s2_r};
  assign rx_byte = rx_word[spi_front_pkg::BYTE_BITS-1:0];
  assign last_bit = (bit_cnt_r == spi_front_pkg::LAST_BIT);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    byte_cnt_nxt = byte_cnt_r;
    op_nxt = op_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    out_nxt = out_r;
    oe_n_nxt = oe_n_r;
    addr_nxt = addr_r;
    mem_rd_nxt = 1'b0;
    load_nxt = mem_rd_r;
    wel_nxt = wel_r;
    pd_nxt = pd_r;
    prog_start_nxt = 1'b0;
    prog_op_nxt = prog_op_r;
    prog_addr_nxt = prog_addr_r;

    if (load_r) begin
      tx_nxt = mem_rdata;
    end

    if (cs_s2_r) begin
      // Deselected: input ignored, output released
      state_nxt = spi_front_pkg::st_idle;
      oe_n_nxt = 1'b1;
      bit_cnt_nxt = 3'h0;
      byte_cnt_nxt = 3'h0;
      // Effects only when a whole number of bytes arrived
      if (cs_rise && state_r == spi_front_pkg::st_absorb &&
          bit_cnt_r == 3'h0) begin
        case (op_r)
          spi_front_pkg::OP_SET_WE: begin
            wel_nxt = 1'b1;
          end
          spi_front_pkg::OP_CLEAR_WE: begin
            wel_nxt = 1'b0;
          end
          spi_front_pkg::OP_POWER_DOWN: begin
            pd_nxt = 1'b1;
            wel_nxt = 1'b0;
          end
          spi_front_pkg::OP_WRITE: begin
            if (wel_r && byte_cnt_r >= spi_front_pkg::WRITE_MIN_BYTES) begin
              prog_start_nxt = 1'b1;
              wel_nxt = 1'b0;
            end
          end
          spi_front_pkg::OP_PAGE_ERASE: begin
            if (wel_r &&
                byte_cnt_r >= spi_front_pkg::PAGE_ERASE_BYTES) begin
              prog_start_nxt = 1'b1;
              wel_nxt = 1'b0;
            end
          end
          spi_front_pkg::OP_CHIP_ERASE_A,
          spi_front_pkg::OP_CHIP_ERASE_B: begin
            if (wel_r) begin
              prog_start_nxt = 1'b1;
              wel_nxt = 1'b0;
            end
          end
          default: begin
          end
        endcase
        if (prog_start_nxt) begin
          prog_op_nxt = op_r;
        end
      end
    end else if (cs_fall) begin
      state_nxt = spi_front_pkg::st_opcode;
      bit_cnt_nxt = 3'h0;
      byte_cnt_nxt = 3'h0;
    end else if (sck_rise) begin
      rx_nxt = rx_word;
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      if (last_bit && byte_cnt_r != spi_front_pkg::BYTE_CNT_MAX) begin
        byte_cnt_nxt = byte_cnt_r + 3'h1;
      end
      case (state_r)
        spi_front_pkg::st_opcode: begin
          if (last_bit) begin
            op_nxt = rx_byte;
            state_nxt = spi_front_pkg::st_ignore;
            if (pd_r) begin
              if (rx_byte == spi_front_pkg::OP_WAKE_UP) begin
                pd_nxt = 1'b0;
              end
            end else if (busy_in &&
                         rx_byte != spi_front_pkg::OP_STATUS_READ) begin
              state_nxt = spi_front_pkg::st_ignore;
            end else begin
              case (rx_byte)
                spi_front_pkg::OP_READ,
                spi_front_pkg::OP_FAST_READ: begin
                  state_nxt = spi_front_pkg::st_addr;
                end
                spi_front_pkg::OP_STATUS_READ: begin
                  state_nxt = spi_front_pkg::st_status;
                  tx_nxt = status_byte;
                end
                spi_front_pkg::OP_WRITE,
                spi_front_pkg::OP_PAGE_ERASE,
                spi_front_pkg::OP_CHIP_ERASE_A,
                spi_front_pkg::OP_CHIP_ERASE_B: begin
                  state_nxt = spi_front_pkg::st_absorb;
                end
                spi_front_pkg::OP_SET_WE,
                spi_front_pkg::OP_CLEAR_WE,
                spi_front_pkg::OP_POWER_DOWN: begin
                  state_nxt = spi_front_pkg::st_absorb;
                end
                default: begin
                  state_nxt = spi_front_pkg::st_ignore;
                end
              endcase
            end
          end
        end
        spi_front_pkg::st_addr: begin
          if (last_bit && byte_cnt_r == spi_front_pkg::ADDR_DONE_CNT) begin
            addr_nxt = rx_word[ADDR_W-1:0];
            if (op_r == spi_front_pkg::OP_FAST_READ) begin
              state_nxt = spi_front_pkg::st_dummy;
            end else begin
              state_nxt = spi_front_pkg::st_read;
              mem_rd_nxt = 1'b1;
            end
          end
        end
        spi_front_pkg::st_dummy: begin
          if (last_bit) begin
            state_nxt = spi_front_pkg::st_read;
            mem_rd_nxt = 1'b1;
          end
        end
        spi_front_pkg::st_read: begin
          // Input ignored; next byte fetched at each byte end
          if (last_bit) begin
            addr_nxt = addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
            mem_rd_nxt = 1'b1;
          end
        end
        spi_front_pkg::st_status: begin
          if (last_bit) begin
            tx_nxt = status_byte;
          end
        end
        spi_front_pkg::st_absorb: begin
          if (last_bit && byte_cnt_r == spi_front_pkg::ADDR_DONE_CNT) begin
            prog_addr_nxt = rx_word[ADDR_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end else if (sck_fall) begin
      if (state_r == spi_front_pkg::st_read ||
          state_r == spi_front_pkg::st_status) begin
        out_nxt = tx_r[7];
        tx_nxt = {tx_r[6:0], 1'b0};
        oe_n_nxt = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= spi_front_pkg::st_idle;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      op_r <= 8'h00;
      rx_r <= 16'h0000;
      tx_r <= 8'h00;
      out_r <= 1'b0;
      oe_n_r <= 1'b1;
      addr_r <= '0;
      mem_rd_r <= 1'b0;
      load_r <= 1'b0;
      wel_r <= spi_front_pkg::WEL_RESET;
      pd_r <= spi_front_pkg::POWER_DOWN_RESET;
      prog_start_r <= 1'b0;
      prog_op_r <= 8'h00;
      prog_addr_r <= '0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      op_r <= op_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      out_r <= out_nxt;
      oe_n_r <= oe_n_nxt;
      addr_r <= addr_nxt;
      mem_rd_r <= mem_rd_nxt;
      load_r <= load_nxt;
      wel_r <= wel_nxt;
      pd_r <= pd_nxt;
      prog_start_r <= prog_start_nxt;
      prog_op_r <= prog_op_nxt;
      prog_addr_r <= prog_addr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_out = out_r;
  assign serial_out_oe_n = oe_n_r;
  assign mem_addr = addr_r;
  assign mem_rd = mem_rd_r;
  assign prog_start = prog_start_r;
  assign prog_op = prog_op_r;
  assign prog_addr = prog_addr_r;
  assign write_enable_latch = wel_r;
  assign power_down = pd_r;

endmodule

`default_nettype wire

// ===== serial_memory_spi_command_front_bench.sv
// Self-checking bench of the serial memory command front.
// Uses the link master model and a simple array stand-in.
`timescale 1ns/1ps
`default_nettype none
module serial_memory_spi_command_front_bench;
  logic clk, srst, busy_in, cs_n, sck, serial_in;
  logic serial_out, serial_out_oe_n, mem_rd, prog_start;
  logic write_enable_latch, power_down;
  logic [11:0] mem_addr, prog_addr;
  logic [7:0] prog_op, rx;
  logic [7:0] mem_rdata = 8'h00;
  int num_errors = 0;
  int n_checks = 0;
  int n_prog = 0;
  serial_memory_spi_command_front uut (.clk(clk), .srst(srst),
    .cs_n(cs_n), .sck(sck), .serial_in(serial_in), .busy_in(busy_in),
    .mem_rdata(mem_rdata), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .prog_start(prog_start), .prog_op(prog_op),
    .prog_addr(prog_addr), .write_enable_latch(write_enable_latch),
    .power_down(power_down));
  spi_master_model m (.cs_n(cs_n), .sck(sck), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));
  // ----------------------------------------
  // Clock, array stand-in, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] mval(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'h5};
  endfunction
  always @(posedge clk) if (mem_rd) mem_rdata <= #1 mval(mem_addr);
  always @(posedge clk) if (prog_start === 1'b1) n_prog++;
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic one(input logic [7:0] op);
    m.sel();
    m.xbits(op, 8, rx);
    m.desel();
  endtask
  task automatic stat(input logic [7:0] e);
    m.sel();
    m.xbits(8'h05, 8, rx);
    m.xbits(8'h00, 8, rx);
    chk(rx, e);
    m.xbits(8'h00, 8, rx);
    chk(rx, e);
    m.desel();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_enable;
    one(8'h06);
    chk(write_enable_latch, 1'b1);
    stat(8'h02);
    one(8'h04);
    chk(write_enable_latch, 1'b0);
  endtask
  task automatic t_refuse;
    m.sel();
    m.xbits(8'h42, 8, rx);
    m.xbits(8'h00, 8, rx);
    m.xbits(8'h10, 8, rx);
    m.desel();
    chk(12'(n_prog), 12'h000);
  endtask
  task automatic t_partial;
    one(8'h06);
    m.sel();
    m.xbits(8'h04, 5, rx);
    m.desel();
    chk(write_enable_latch, 1'b1);
    m.sel();
    m.xbits(8'h04, 8, rx);
    m.xbits(8'h00, 3, rx);
    m.desel();
    chk(write_enable_latch, 1'b1);
    one(8'h04);
  endtask
  task automatic t_prog;
    logic [7:0] ops [4] = '{8'h02, 8'h42, 8'h60, 8'hc7};
    logic [7:0] hdr [3] = '{8'h0b, 8'hcd, 8'h77};
    int nb [4] = '{3, 2, 0, 0};
    for (int i = 0; i < 4; i++) begin
      one(8'h06);
      m.sel();
      m.xbits(ops[i], 8, rx);
      for (int j = 0; j < nb[i]; j++) m.xbits(hdr[j], 8, rx);
      m.desel();
      chk(12'(n_prog), 12'(i + 1));
      chk(prog_op, ops[i]);
      chk(write_enable_latch, 1'b0);
      if (nb[i] > 0) chk(prog_addr, 12'hbcd);
    end
  endtask
  task automatic t_read;
    one(8'h06);
    m.cpol = 1'b1;
    m.sel();
    m.xbits(8'h03, 8, rx);
    m.xbits(8'h0f, 8, rx);
    m.xbits(8'hfe, 8, rx);
    for (int k = 0; k < 3; k++) begin
      m.xbits(8'ha5, 8, rx);
      chk(rx, mval(12'hffe + 12'(k)));
    end
    m.desel();
    m.cpol = 1'b0;
    chk(write_enable_latch, 1'b1);
    one(8'h04);
    m.sel();
    m.xbits(8'h0b, 8, rx);
    m.xbits(8'h00, 8, rx);
    m.xbits(8'h10, 8, rx);
    m.xbits(8'h00, 8, rx);
    m.xbits(8'h00, 8, rx);
    chk(rx, mval(12'h010));
    m.desel();
  endtask
  task automatic t_unknown;
    m.oe_seen = 1'b0;
    m.sel();
    m.xbits(8'h9f, 8, rx);
    m.xbits(8'h00, 8, rx);
    m.desel();
    chk(m.oe_seen, 1'b0);
  endtask
  task automatic t_power;
    one(8'h06);
    one(8'hb9);
    chk(power_down, 1'b1);
    chk(write_enable_latch, 1'b0);
    one(8'h06);
    chk(write_enable_latch, 1'b0);
    one(8'hab);
    chk(power_down, 1'b0);
  endtask
  initial begin
    srst = 1'b1;
    busy_in = 1'b0;
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(write_enable_latch, 1'b0);
    chk(serial_out_oe_n, 1'b1);
    t_enable();
    t_refuse();
    t_partial();
    t_prog();
    t_read();
    t_unknown();
    t_power();
    busy_in = 1'b1;
    one(8'h06);
    chk(write_enable_latch, 1'b0);
    stat(8'h01);
    busy_in = 1'b0;
    end_sim();
  end
endmodule
`default_nettype wire

// ===== serial_memory_spi_command_front_sva.sv
// Checker of the serial memory command front.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module serial_memory_spi_command_front_sva #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_rd,
  input wire logic prog_start,
  input wire logic [7:0] prog_op,
  input wire logic write_enable_latch
);
  logic seen_r;
  logic seen_nxt;
  logic [ADDR_W-1:0] last_r;
  logic [ADDR_W-1:0] last_nxt;
  // ----------------------------------------
  // Read address tracking
  // ----------------------------------------
  always_comb begin
    seen_nxt = cs_n ? 1'b0 : (seen_r | mem_rd);
    last_nxt = mem_rd ? mem_addr : last_r;
  end
  always_ff @(posedge clk) begin
    seen_r <= srst ? 1'b0 : seen_nxt;
    last_r <= last_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_oe_idle: assert property (
    cs_n [*6] |-> serial_out_oe_n) else $error("output not released");
  chk_prog_wel: assert property (
    prog_start |-> $past(write_enable_latch)) else $error("start no latch");
  chk_prog_clear: assert property (
    prog_start |-> !write_enable_latch) else $error("latch kept");
  chk_prog_op: assert property (
    prog_start |-> prog_op inside {8'h02, 8'h42, 8'h60, 8'hc7})
    else $error("bad start opcode");
  chk_prog_pulse: assert property (
    prog_start |=> !prog_start) else $error("start too long");
  chk_wel_deselect: assert property (
    $changed(write_enable_latch) |-> $past(cs_n) && $past(cs_n, 2))
    else $error("latch moved in frame");
  chk_rd_incr: assert property (
    mem_rd && seen_r |-> mem_addr == last_r + 1'b1)
    else $error("read address step");
  chk_out_fall: assert property (
    $changed(serial_out) |-> !$past(sck, 2) || !$past(sck, 3))
    else $error("output moved off fall");
  cover property (prog_start);
  cover property (mem_rd && seen_r);
  cover property ($fell(serial_out_oe_n));
endmodule
bind serial_memory_spi_command_front serial_memory_spi_command_front_sva
  #(.ADDR_W(ADDR_W)) u_sva (.clk(clk), .srst(srst), .cs_n(cs_n),
  .sck(sck), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .prog_start(prog_start),
  .prog_op(prog_op), .write_enable_latch(write_enable_latch));
`default_nettype wire

// ===== spi_front_pkg.sv
// Constants, opcodes and state codes of the serial memory command front.
// Assumes a single system clock domain; the link pins are synchronised.
package spi_front_pkg;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_CLEAR_WE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_SET_WE = 8'h06;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h42;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_WAKE_UP = 8'hab;

  // ----------------------------------------------------------------
  // Status byte layout
  // ----------------------------------------------------------------
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_WEL_BIT = 1;
  localparam logic [7:0] STATUS_RESERVED = 8'h00;

  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BITS_USED = 12;
  localparam int ADDR_BITS_SENT = 16;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
  localparam logic [2:0] ADDR_DONE_CNT = 3'h2;
  localparam logic [2:0] WRITE_MIN_BYTES = 3'h4;
  localparam logic [2:0] PAGE_ERASE_BYTES = 3'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic WEL_RESET = 1'b0;
  localparam logic POWER_DOWN_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Protocol states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_opcode = 3'b001,
    st_addr = 3'b010,
    st_dummy = 3'b011,
    st_read = 3'b100,
    st_status = 3'b101,
    st_absorb = 3'b110,
    st_ignore = 3'b111
  } front_state_t;

endpackage

// ===== spi_master_model.sv
// Link master model: drives select, clock and data in.
// Bench calls its tasks on a grid aligned to the system clock.
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  output logic cs_n,
  output logic sck,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  logic cpol = 1'b0;
  logic oe_seen = 1'b0;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    serial_in = 1'b0;
  end
  task automatic sel;
    sck = cpol;
    #40;
    cs_n = 1'b0;
    #80;
  endtask
  task automatic xbits(input logic [7:0] tx, input int n,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      serial_in = tx[7-i];
      #40;
      sck = 1'b1;
      #35;
      oe_seen = oe_seen | ~serial_out_oe_n;
      rx = {rx[6:0], serial_out_oe_n ? ~rx[0] : serial_out};
      #5;
    end
  endtask
  task automatic desel;
    sck = cpol;
    #40;
    cs_n = 1'b1;
    serial_in = ~serial_in;
    #80;
  endtask
endmodule
`default_nettype wire
